//--- src/pss_pkg.sv
// Purpose: Shared constants and types of the operating point sequencer
// Assumes: 125 MHz clock, 32-bit classic Wishbone register port
// Notes:   Operating point = core clock ratio plus six-bit voltage code
package pss_pkg;
  localparam int          CLK_NS          = 8;
  localparam int          VID_STEP_NS     = 200;
  localparam int          PLL_RELOCK_NS   = 5000;
  localparam int          UNAVAIL_MAX_NS  = 10000;
  localparam int          THERM_HOLD_NS   = 100000;
  localparam int          VID_STEP_CYC    = (VID_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int          RELOCK_CYC      = (PLL_RELOCK_NS + CLK_NS - 1) / CLK_NS;
  localparam int          UNAVAIL_MAX_CYC = UNAVAIL_MAX_NS / CLK_NS;
  localparam int          THERM_HOLD_CYC  = THERM_HOLD_NS / CLK_NS;

  typedef struct packed {
    logic [4:0] ratio;
    logic [5:0] voltage_code_out;
  } pss_pt_s;

  localparam logic [4:0]  RST_RATIO       = 5'h0C;
  localparam logic [5:0]  RST_VID         = 6'h11;
  localparam logic [5:0]  VID_OFF         = 6'h00;
  localparam pss_pt_s     RST_PT          = '{ratio: RST_RATIO, voltage_code_out: RST_VID};
  localparam pss_pt_s     RST_THR_PT      = '{ratio: 5'h06, voltage_code_out: 6'h29};
  localparam pss_pt_s     RST_HALT_PT     = '{ratio: 5'h06, voltage_code_out: 6'h29};

  localparam logic [7:0]  ADR_REQ0        = 8'h00;
  localparam logic [7:0]  ADR_REQ1        = 8'h04;
  localparam logic [7:0]  ADR_CTRL        = 8'h08;
  localparam logic [7:0]  ADR_THR_PT      = 8'h0C;
  localparam logic [7:0]  ADR_HALT_PT     = 8'h10;
  localparam logic [7:0]  ADR_STATUS      = 8'h14;
  localparam logic [7:0]  ADR_EVENT       = 8'h18;

  localparam int          PT_VID_LSB      = 0;
  localparam int          PT_RATIO_LSB    = 8;
  localparam int          CTL_HALT_EN     = 0;
  localparam int          CTL_THR_EN      = 1;
  localparam int          ST_BUSY         = 16;
  localparam int          ST_IN_HALT      = 17;
  localparam int          ST_THR_ACT      = 18;
  localparam int          ST_PENDING      = 19;
  localparam int          EV_THR_DOWN     = 0;
  localparam int          EV_THR_UP       = 1;

  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_VRAMP  = 2'b01,
    S_RELOCK = 2'b10
  } pss_state_e;
endpackage

//--- src/pss_sequencer.sv
// Purpose: Voltage code and core ratio sequencer for a two-core package
// Assumes: All inputs synchronous to clk_i; regulator follows the code
// Notes:   Registers reached over classic Wishbone, one word each
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Contract
// [R1] Going up in frequency: step voltage code first, then relock the PLL.
// [R2] Going down in frequency: relock the PLL first, then step voltage code.
// [R3] Requests accepted anytime; a new one waits until the running one ends.
// [R4] Core unavailable for at most 10 us during a frequency change.
// [R5] Block-next-request is asserted while the core is unavailable.
// [R6] Voltage code moves one step at a time at an internal pace.
// [R7] Overheat with throttling enabled moves to the programmed throttle point.
// [R8] After a fixed wait, if cool, return to the previous point.
// [R9] Every thermal transition, down and up, raises a software event.
// [R10] Each core has its own request register; one shared package point.
// [R11] Resolved request is the higher ratio and higher voltage of both cores.
// [R12] Extended halt only when enabled and both cores halted.
// [R13] One halted core is halted alone; no package extended halt.
// [R14] Extended halt lowers only core ratio and voltage, bus clock unchanged.
// [R15] Extended halt entry: lower ratio first, then lower voltage code.
// [R16] Snoops stay serviced while in extended halt.
// [R17] Any break event leaves extended halt.
// [R18] Extended halt exit: restore voltage code first, then ratio.
// [R19] Core ratio is an integer multiple of bus clock, default fixed.
// [R20] Six-bit voltage code; zero is off, code one highest supply.
module pss_sequencer #(
  parameter int THERM_HOLD_CYC = pss_pkg::THERM_HOLD_CYC
) (
  input  wire  logic        clk_i,
  input  wire  logic        rst_i,
  input  wire  logic        wb_cyc_i,
  input  wire  logic        wb_stb_i,
  input  wire  logic        wb_we_i,
  input  wire  logic [7:0]  wb_adr_i,
  input  wire  logic [3:0]  wb_sel_i,
  input  wire  logic [31:0] wb_dat_i,
  output logic       [31:0] wb_dat_o,
  output logic              wb_ack_o,
  input  wire  logic [1:0]  core_halt_i,
  input  wire  logic        break_event_i,
  input  wire  logic        overheat_i,
  output logic [5:0]        voltage_code_out_o,
  output logic [4:0]        core_ratio_o,
  output logic              pll_relock_o,
  output logic              block_next_request_n_o,
  output logic [1:0]        core_stopped_o,
  output logic              extended_halt_state_o,
  output logic              therm_event_o
);
  import pss_pkg::*;

  pss_state_e  state_reg;
  pss_pt_s     req_reg [2];
  pss_pt_s     thr_pt_reg;
  pss_pt_s     halt_pt_reg;
  pss_pt_s     tgt_reg;
  pss_pt_s     sw_pt;
  pss_pt_s     base_pt;
  logic        halt_en_reg;
  logic        thr_en_reg;
  logic        vfirst_reg;
  logic        in_halt_reg;
  logic        thr_act_reg;
  logic [1:0]  evt_reg;
  logic [10:0] tmr_reg;
  logic [31:0] hold_reg;
  logic        wb_req;
  logic        wr;
  logic        hold_done;
  logic        go_halt;
  logic        go_wake;
  logic        go_thr_dn;
  logic        go_thr_up;
  logic        go_sw;
  logic        start;
  logic [31:0] rd_data;
  logic [1:0]  evt_set;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr     = wb_req & wb_we_i;

  // Package request from the two per-core requests
  always_comb begin
    sw_pt.ratio = (req_reg[0].ratio > req_reg[1].ratio) ? req_reg[0].ratio
                                                        : req_reg[1].ratio; // [R11]
    sw_pt.voltage_code_out   = (req_reg[0].voltage_code_out < req_reg[1].voltage_code_out) ? req_reg[0].voltage_code_out
                                                    : req_reg[1].voltage_code_out; // [R11]
    base_pt     = thr_act_reg ? thr_pt_reg : sw_pt;
  end

  // Start decisions, only taken while no transition runs
  assign hold_done = (hold_reg >= 32'(THERM_HOLD_CYC));
  assign go_wake   = in_halt_reg & break_event_i; // [R17]
  assign go_halt   = ~in_halt_reg & halt_en_reg & (&core_halt_i); // [R12]
  assign go_thr_dn = ~in_halt_reg & ~go_halt & thr_en_reg & overheat_i & ~thr_act_reg; // [R7]
  assign go_thr_up = ~in_halt_reg & ~go_halt & thr_act_reg & hold_done & ~overheat_i; // [R8]
  assign go_sw     = ~in_halt_reg & ~go_halt & ~go_thr_dn & ~go_thr_up & (base_pt != tgt_reg);
  assign start     = (state_reg == S_IDLE) & (go_wake | go_halt | go_thr_dn | go_thr_up | go_sw); // [R3]

  // Wishbone slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h0000_0000;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      ADR_REQ0: begin
        rd_data[PT_RATIO_LSB +: 5] = req_reg[0].ratio;
        rd_data[PT_VID_LSB +: 6]   = req_reg[0].voltage_code_out;
      end
      ADR_REQ1: begin
        rd_data[PT_RATIO_LSB +: 5] = req_reg[1].ratio;
        rd_data[PT_VID_LSB +: 6]   = req_reg[1].voltage_code_out;
      end
      ADR_CTRL: begin
        rd_data[CTL_HALT_EN] = halt_en_reg;
        rd_data[CTL_THR_EN]  = thr_en_reg;
      end
      ADR_THR_PT: begin
        rd_data[PT_RATIO_LSB +: 5] = thr_pt_reg.ratio;
        rd_data[PT_VID_LSB +: 6]   = thr_pt_reg.voltage_code_out;
      end
      ADR_HALT_PT: begin
        rd_data[PT_RATIO_LSB +: 5] = halt_pt_reg.ratio;
        rd_data[PT_VID_LSB +: 6]   = halt_pt_reg.voltage_code_out;
      end
      ADR_STATUS: begin
        rd_data[PT_RATIO_LSB +: 5] = core_ratio_o;
        rd_data[PT_VID_LSB +: 6]   = voltage_code_out_o;
        rd_data[ST_BUSY]           = (state_reg != S_IDLE);
        rd_data[ST_IN_HALT]        = in_halt_reg;
        rd_data[ST_THR_ACT]        = thr_act_reg;
        rd_data[ST_PENDING]        = (state_reg != S_IDLE) & (base_pt != tgt_reg);
      end
      ADR_EVENT: rd_data[1:0] = evt_reg;
      default:   rd_data = 32'h0000_0000;
    endcase
  end

  // Per-core request and configuration registers
  generate
    for (genvar c = 0; c < 2; c++) begin : g_req
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          req_reg[c] <= RST_PT; // [R10]
        end else if (wr && wb_adr_i == (c == 0 ? ADR_REQ0 : ADR_REQ1)) begin
          if (wb_sel_i[0] && wb_dat_i[PT_VID_LSB +: 6] != VID_OFF) begin
            req_reg[c].voltage_code_out <= wb_dat_i[PT_VID_LSB +: 6]; // [R20]
          end
          if (wb_sel_i[1] && wb_dat_i[PT_RATIO_LSB +: 5] != 5'h00) begin
            req_reg[c].ratio <= wb_dat_i[PT_RATIO_LSB +: 5];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halt_en_reg <= 1'b0;
      thr_en_reg  <= 1'b0;
      thr_pt_reg  <= RST_THR_PT;
      halt_pt_reg <= RST_HALT_PT;
    end else if (wr && wb_sel_i[0]) begin
      if (wb_adr_i == ADR_CTRL) begin
        halt_en_reg <= wb_dat_i[CTL_HALT_EN];
        thr_en_reg  <= wb_dat_i[CTL_THR_EN];
      end
      if (wb_adr_i == ADR_THR_PT && wb_dat_i[5:0] != VID_OFF) begin
        thr_pt_reg.voltage_code_out <= wb_dat_i[PT_VID_LSB +: 6];
        thr_pt_reg.ratio <= wb_dat_i[PT_RATIO_LSB +: 5];
      end
      if (wb_adr_i == ADR_HALT_PT && wb_dat_i[5:0] != VID_OFF) begin
        halt_pt_reg.voltage_code_out <= wb_dat_i[PT_VID_LSB +: 6];
        halt_pt_reg.ratio <= wb_dat_i[PT_RATIO_LSB +: 5];
      end
    end
  end

  // Thermal events: sticky, write one to clear, set beats clear
  assign evt_set = {start & go_thr_up, start & go_thr_dn};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_reg       <= 2'b00;
      therm_event_o <= 1'b0;
    end else begin
      therm_event_o <= |evt_set; // [R9]
      if (wr && wb_adr_i == ADR_EVENT && wb_sel_i[0]) begin
        evt_reg <= (evt_reg & ~wb_dat_i[1:0]) | evt_set; // [R9]
      end else begin
        evt_reg <= evt_reg | evt_set; // [R9]
      end
    end
  end

  // Thermal throttle state and hold timer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thr_act_reg <= 1'b0;
      hold_reg    <= 32'h0000_0000;
    end else begin
      if (start && go_thr_dn) begin
        thr_act_reg <= 1'b1; // [R7]
      end else if (start && go_thr_up) begin
        thr_act_reg <= 1'b0; // [R8]
      end
      if (!thr_act_reg || state_reg != S_IDLE || (hold_done && overheat_i)) begin
        hold_reg <= 32'h0000_0000; // [R8]
      end else if (!hold_done) begin
        hold_reg <= hold_reg + 32'h0000_0001;
      end
    end
  end

  // Extended halt tracking and per-core stop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_halt_reg           <= 1'b0;
      extended_halt_state_o <= 1'b0;
      core_stopped_o        <= 2'b00;
    end else begin
      core_stopped_o <= core_halt_i; // [R13]
      if (start && go_halt) begin
        in_halt_reg <= 1'b1; // [R12]
      end else if (start && go_wake) begin
        in_halt_reg <= 1'b0; // [R17]
      end
      extended_halt_state_o <= in_halt_reg & (state_reg == S_IDLE); // [R16]
    end
  end

  // Transition sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg              <= S_IDLE;
      tgt_reg                <= RST_PT;
      vfirst_reg             <= 1'b0;
      tmr_reg                <= 11'h000;
      voltage_code_out_o     <= RST_VID; // [R20]
      core_ratio_o           <= RST_RATIO; // [R19]
      pll_relock_o           <= 1'b0;
      block_next_request_n_o <= 1'b1;
    end else begin
      case (state_reg)
        S_IDLE: begin
          tmr_reg <= 11'h000;
          if (start) begin
            if (go_halt) begin
              tgt_reg    <= halt_pt_reg; // [R14]
              vfirst_reg <= 1'b0; // [R15]
              state_reg  <= S_RELOCK;
            end else if (go_wake) begin
              tgt_reg    <= base_pt;
              vfirst_reg <= 1'b1; // [R18]
              state_reg  <= S_VRAMP;
            end else begin
              tgt_reg <= go_thr_dn ? thr_pt_reg : (go_thr_up ? sw_pt : base_pt);
              if ((go_thr_dn ? thr_pt_reg.ratio : (go_thr_up ? sw_pt.ratio : base_pt.ratio))
                  > core_ratio_o) begin
                vfirst_reg <= 1'b1; // [R1]
                state_reg  <= S_VRAMP;
              end else begin
                vfirst_reg <= 1'b0; // [R2]
                state_reg  <= S_RELOCK;
              end
            end
          end
        end
        S_VRAMP: begin
          if (voltage_code_out_o == tgt_reg.voltage_code_out) begin
            tmr_reg   <= 11'h000;
            state_reg <= vfirst_reg ? S_RELOCK : S_IDLE; // [R1]
          end else if (tmr_reg == 11'(VID_STEP_CYC - 1)) begin
            tmr_reg <= 11'h000;
            if (voltage_code_out_o > tgt_reg.voltage_code_out) begin
              voltage_code_out_o <= voltage_code_out_o - 6'h01; // [R6]
            end else begin
              voltage_code_out_o <= voltage_code_out_o + 6'h01; // [R6]
            end
          end else begin
            tmr_reg <= tmr_reg + 11'h001;
          end
        end
        S_RELOCK: begin
          pll_relock_o           <= 1'b1;
          block_next_request_n_o <= 1'b0; // [R5]
          if (tmr_reg == 11'(RELOCK_CYC - 1)) begin
            tmr_reg                <= 11'h000;
            core_ratio_o           <= tgt_reg.ratio; // [R19]
            pll_relock_o           <= 1'b0;
            block_next_request_n_o <= 1'b1; // [R4]
            state_reg              <= vfirst_reg ? S_IDLE : S_VRAMP; // [R2]
          end else begin
            tmr_reg <= tmr_reg + 11'h001;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // Checks
  logic [11:0] unavail_cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i || block_next_request_n_o) begin
      unavail_cnt <= 12'h000;
    end else begin
      unavail_cnt <= unavail_cnt + 12'h001;
    end
  end

  a_unavail_bound: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    unavail_cnt <= 12'(UNAVAIL_MAX_CYC)) else $error("core unavailable too long");

  a_bnr_relock: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    pll_relock_o |-> !block_next_request_n_o) else $error("snoop not blocked in relock");

  a_vid_single_step: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    $changed(voltage_code_out_o) |-> (voltage_code_out_o - $past(voltage_code_out_o) == 6'h01
      || $past(voltage_code_out_o) - voltage_code_out_o == 6'h01))
    else $error("voltage code jumped");

  a_up_order: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    (core_ratio_o > $past(core_ratio_o)) |-> voltage_code_out_o == tgt_reg.voltage_code_out)
    else $error("ratio raised before voltage");

  a_down_order: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    ($changed(voltage_code_out_o) && !vfirst_reg) |-> core_ratio_o == tgt_reg.ratio)
    else $error("voltage moved before relock");

  a_halt_entry: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    $rose(in_halt_reg) |-> $past(halt_en_reg) && $past(&core_halt_i))
    else $error("extended halt without both cores");

  a_halt_snoop: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
    extended_halt_state_o |-> block_next_request_n_o) else $error("snoops blocked in halt");

  a_therm_event: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    (start && (go_thr_dn || go_thr_up)) |=> therm_event_o && (evt_reg != 2'b00))
    else $error("thermal transition without event");

  a_resolve_max: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    sw_pt.ratio >= req_reg[0].ratio && sw_pt.ratio >= req_reg[1].ratio
    && sw_pt.voltage_code_out <= req_reg[0].voltage_code_out && sw_pt.voltage_code_out <= req_reg[1].voltage_code_out)
    else $error("package request not highest");

  a_vid_on: assert property (@(posedge clk_i) disable iff (rst_i) // [R20]
    voltage_code_out_o != VID_OFF) else $error("supply turned off");

  a_relock_vid_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    (state_reg == S_RELOCK) |-> $stable(voltage_code_out_o))
    else $error("voltage code moved during relock");

  a_ratio_at_relock: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
    $changed(core_ratio_o) |-> $past(state_reg) == S_RELOCK)
    else $error("ratio changed outside relock");

  a_event_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    therm_event_o |=> !therm_event_o)
    else $error("thermal event longer than one cycle");

  a_halt_point: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    $rose(extended_halt_state_o) |-> core_ratio_o == tgt_reg.ratio
      && voltage_code_out_o == tgt_reg.voltage_code_out)
    else $error("extended halt not at halt point");
endmodule

`default_nettype wire

//--- sim/pss_vreg_model.sv
// Purpose: Behavioural board regulator that follows the six-bit voltage code
// Assumes: Code sampled on clk_i; regulator tracks one step at a time
// Notes:   bad_o counts codes that are off or jump by more than one step
`timescale 1ns/100ps
`default_nettype none
module pss_vreg_model
  import pss_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [5:0] code_i,
  output logic      [7:0] bad_o
);
  logic [5:0] last_reg;

  // Supply follows the code; a zero code or a jump is a ramp fault
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_reg <= RST_VID;
      bad_o    <= 8'h00;
    end else begin
      last_reg <= code_i;
      if (code_i == VID_OFF || (code_i != last_reg && code_i != last_reg + 6'h01
          && code_i != last_reg - 6'h01)) begin
        bad_o <= bad_o + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/perf_state_transition_sequencer_tb_top.sv
// Purpose: Self-checking bench for the operating point sequencer
// Assumes: Classic Wishbone master, throttle hold shortened to 20 cycles
// Notes:   Order of code and ratio changes is timed by a monitor
`timescale 1ns/100ps
`default_nettype none
module perf_state_transition_sequencer_tb_top;
  import pss_pkg::*;
  localparam logic [31:0] PM = 32'h00001F3F;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        break_event_i, overheat_i, pll_relock_o, block_next_request_n_o;
  logic        extended_halt_state_o, therm_event_o;
  logic [7:0]  wb_adr_i, bad;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [1:0]  core_halt_i, core_stopped_o;
  logic [5:0]  voltage_code_out_o, pv;
  logic [4:0]  core_ratio_o, pr;
  int          miscompares, total_checks, ev_cnt, blk;
  time         fv_t, r_t;

  pss_sequencer #(.THERM_HOLD_CYC(20)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .core_halt_i(core_halt_i), .break_event_i(break_event_i), .overheat_i(overheat_i),
    .voltage_code_out_o(voltage_code_out_o), .core_ratio_o(core_ratio_o),
    .pll_relock_o(pll_relock_o), .block_next_request_n_o(block_next_request_n_o),
    .core_stopped_o(core_stopped_o), .extended_halt_state_o(extended_halt_state_o),
    .therm_event_o(therm_event_o));
  pss_vreg_model vreg (.clk_i(clk_i), .rst_i(rst_i), .code_i(voltage_code_out_o), .bad_o(bad));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic logic [31:0] pt(input logic [4:0] r, input logic [5:0] v);
    return {19'h0, r, 2'b00, v};
  endfunction

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    // Ack and read data are sampled at the rising edge, then released
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask

  task automatic wait_idle();
    logic [31:0] s;
    int n;
    int k;
    repeat (4) @(posedge clk_i);
    n = 0;
    k = 0;
    // Two idle reads in a row, so the idle cycle between chained moves is skipped
    do begin
      wb(1'b0, ADR_STATUS, 32'h0, s);
      k = (s[ST_BUSY] === 1'b0) ? k + 1 : 0;
      n++;
    end while (k < 2 && n < 3000);
    check({31'h0, s[ST_BUSY]}, 32'h0);
  endtask

  task automatic wait_ev(input int n);
    int k;
    k = 0;
    while (ev_cnt < n && k < 20000) begin
      @(posedge clk_i);
      k++;
    end
  endtask

  task automatic track();
    fv_t = 0;
    r_t = 0;
  endtask

  // Watches sequencing of code, ratio and bus blocking between edges
  always @(negedge clk_i) begin
    if (rst_i === 1'b0) begin
      if (voltage_code_out_o !== pv && fv_t == 0) fv_t = $time;
      if (core_ratio_o !== pr && r_t == 0) r_t = $time;
      if (therm_event_o === 1'b1) ev_cnt++;
      check({31'h0, block_next_request_n_o ^ pll_relock_o}, 32'h1);
      if (extended_halt_state_o === 1'b1) check({31'h0, block_next_request_n_o}, 32'h1);
      if (block_next_request_n_o === 1'b0) blk++;
      else if (blk != 0) begin
        check({31'h0, blk <= UNAVAIL_MAX_CYC}, 32'h1);
        blk = 0;
      end
    end
    pv = voltage_code_out_o;
    pr = core_ratio_o;
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end

  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, break_event_i, overheat_i} = 6'h01 << 5;
    {wb_adr_i, wb_dat_i, wb_sel_i, core_halt_i} = '0;
    wb_sel_i = 4'hF;
    {ev_cnt, blk, miscompares, total_checks} = '0;
    track();
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADR_STATUS, PM, pt(RST_RATIO, RST_VID));
    rd(8'h1C, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
    track();
    wr(ADR_REQ0, pt(5'h10, 6'h0F));
    wait_idle();
    rd(ADR_STATUS, PM, pt(5'h10, 6'h0F));
    check({31'h0, fv_t != 0 && fv_t < r_t}, 32'h1);
    track();
    wr(ADR_REQ0, pt(RST_RATIO, RST_VID));
    wait_idle();
    rd(ADR_STATUS, PM, pt(RST_RATIO, RST_VID));
    check({31'h0, r_t != 0 && r_t < fv_t}, 32'h1);
    $display("test up down done");
    wr(ADR_REQ0, pt(5'h10, 6'h0F));
    wr(ADR_REQ1, pt(5'h0E, 6'h0D));
    rd(ADR_STATUS, 32'h1 << ST_PENDING, 32'h1 << ST_PENDING);
    wait_idle();
    rd(ADR_STATUS, PM, pt(5'h10, 6'h0D));
    rd(ADR_REQ0, PM, pt(5'h10, 6'h0F));
    rd(ADR_REQ1, PM, pt(5'h0E, 6'h0D));
    $display("test resolve done");
    wr(ADR_CTRL, 32'h2);
    overheat_i <= 1'b1;
    wait_ev(1);
    wait_idle();
    rd(ADR_STATUS, PM, pt(5'h06, 6'h29));
    rd(ADR_EVENT, 32'h3, 32'h1);
    overheat_i <= 1'b0;
    wait_ev(2);
    wait_idle();
    rd(ADR_STATUS, PM, pt(5'h10, 6'h0D));
    rd(ADR_EVENT, 32'h3, 32'h3);
    check(ev_cnt, 32'h2);
    wr(ADR_EVENT, 32'h3);
    rd(ADR_EVENT, 32'h3, 32'h0);
    $display("test thermal done");
    wr(ADR_CTRL, 32'h0);
    core_halt_i <= 2'b01;
    repeat (6) @(posedge clk_i);
    check({30'h0, core_stopped_o}, 32'h1);
    check({31'h0, extended_halt_state_o}, 32'h0);
    core_halt_i <= 2'b11;
    repeat (10) @(posedge clk_i);
    check({31'h0, extended_halt_state_o}, 32'h0);
    track();
    wr(ADR_CTRL, 32'h1);
    wait_idle();
    check({31'h0, extended_halt_state_o}, 32'h1);
    rd(ADR_STATUS, PM, pt(5'h06, 6'h29));
    check({31'h0, r_t != 0 && r_t < fv_t}, 32'h1);
    track();
    break_event_i <= 1'b1;
    core_halt_i <= 2'b00;
    wait_idle();
    break_event_i <= 1'b0;
    check({31'h0, extended_halt_state_o}, 32'h0);
    rd(ADR_STATUS, PM, pt(5'h10, 6'h0D));
    check({31'h0, fv_t != 0 && fv_t < r_t}, 32'h1);
    check({24'h0, bad}, 32'h0);
    $display("test halt done");
    complete_run();
  end
endmodule
`default_nettype wire
